// *** pkg/tpgip_defines.vh ***
// constants for the three-phase gate command controller
// assumes a 20 MHz clock; included by bare name
`ifndef TPGIP_DEFINES_VH
`define TPGIP_DEFINES_VH
`define TPGIP_CLK_HZ        20000000
`define TPGIP_DEAD_NS       2000
`define TPGIP_DEAD_CYC      ((`TPGIP_DEAD_NS * (`TPGIP_CLK_HZ / 1000000) + 999) / 1000)
`define TPGIP_MINPULSE_NS   1500
`define TPGIP_MINPULSE_CYC  ((`TPGIP_MINPULSE_NS * (`TPGIP_CLK_HZ / 1000000) + 999) / 1000)
`define TPGIP_FHOLD_NS      12000
`define TPGIP_FHOLD_CYC     ((`TPGIP_FHOLD_NS * (`TPGIP_CLK_HZ / 1000000)) / 1000)
`define TPGIP_FREQ_MIN_HZ   5000
`define TPGIP_FREQ_MAX_HZ   20000
`define TPGIP_PER_MAX_CYC   (`TPGIP_CLK_HZ / `TPGIP_FREQ_MIN_HZ)
`define TPGIP_PER_MIN_CYC   (`TPGIP_CLK_HZ / `TPGIP_FREQ_MAX_HZ)
`define TPGIP_RESUME_S      2
`define TPGIP_RESUME_CYC    (`TPGIP_RESUME_S * `TPGIP_CLK_HZ)
// register addresses
`define TPGIP_A_CTRL        4'h0
`define TPGIP_A_PERIOD      4'h1
`define TPGIP_A_DUTY0       4'h2
`define TPGIP_A_STATUS      4'h5
`define TPGIP_A_DEAD        4'h6
// control bits
`define TPGIP_C_RUN         0
`define TPGIP_C_HOT         1
`define TPGIP_C_CLRLATCH    2
// status bits
`define TPGIP_S_RUN         0
`define TPGIP_S_FAULT       1
`define TPGIP_S_LATCH       2
`define TPGIP_S_WAIT        3
`define TPGIP_S_HOT         4
`define TPGIP_PER_RST       16'h03E8
`define TPGIP_ZERO16        16'h0000
`endif

// *** hdl/tpgip_phase.v ***
// one phase: duty compare, dead time and minimum pulse for the command pair
// assumes carrier count and enable shared by all phases
`timescale 1ns/1ps
`include "tpgip_defines.vh"
module tpgip_phase #(
	parameter CW = 16
) (
	// clock and reset
	input  wire          clk,
	input  wire          rst_b,
	// control
	input  wire          enable,
	input  wire [CW-1:0] count,
	input  wire [CW-1:0] duty,
	input  wire [CW-1:0] dead,
	// commands
	output reg           high_side_command,
	output reg           low_side_command
);
	reg          want_high;
	reg [CW-1:0] hold;
	reg          next_high;
	reg          next_low;
	reg [CW-1:0] next_hold;
	wire         dead_done;
	wire         pulse_done;

	assign dead_done  = (hold >= dead);
	assign pulse_done = (hold >= `TPGIP_MINPULSE_CYC);

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			want_high <= 1'b0;
		else
			want_high <= (count < duty);
	end

	// hold counts cycles since the last command edge
	always @* begin
		next_high = high_side_command;
		next_low  = low_side_command;
		next_hold = (hold == {CW{1'b1}}) ? hold : hold + 1'b1;
		if (!enable) begin
			next_high = 1'b0;
			next_low  = 1'b0;
			// a forced drop is an edge too: restart dead time and pulse count
			if (high_side_command || low_side_command)
				next_hold = {CW{1'b0}};
		end else if (high_side_command) begin
			if (!want_high && pulse_done) begin
				next_high = 1'b0;
				next_hold = {CW{1'b0}};
			end
		end else if (low_side_command) begin
			if (want_high && pulse_done) begin
				next_low  = 1'b0;
				next_hold = {CW{1'b0}};
			end
		end else if (dead_done && pulse_done) begin
			if (want_high)
				next_high = 1'b1;
			else
				next_low = 1'b1;
			next_hold = {CW{1'b0}};
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			high_side_command <= 1'b0;
			low_side_command  <= 1'b0;
			hold              <= {CW{1'b0}};
		end else begin
			high_side_command <= next_high;
			low_side_command  <= next_low;
			hold              <= next_hold;
		end
	end
endmodule

// *** hdl/tpgip_resume.v ***
// overcurrent resume timer: counts a long wait after a fault
// assumes start is a one-cycle pulse
`timescale 1ns/1ps
`include "tpgip_defines.vh"
module tpgip_resume #(
	parameter RESUME_CYC = `TPGIP_RESUME_CYC
) (
	// clock and reset
	input  wire clk,
	input  wire rst_b,
	// control
	input  wire start,
	// status
	output reg  waiting
);
	reg [31:0] cnt;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt     <= 32'h0000_0000;
			waiting <= 1'b0;
		end else if (start) begin
			cnt     <= 32'h0000_0000;
			waiting <= 1'b1;
		end else if (waiting) begin
			if (cnt >= RESUME_CYC - 1)
				waiting <= 1'b0;
			else
				cnt <= cnt + 32'h0000_0001;
		end
	end
endmodule

// *** hdl/tpgip_ctrl.v ***
// three-phase gate command controller: carrier, per-phase commands, fault reaction
// assumes device fault line sampled synchronous to clk, pulled high when idle
// Contract
// - controller inserts dead time between commands
// - every command pulse at least 1.5 us (a forced drop when enable falls or the fault mask cuts it short)
// - carrier frequency between 5 and 20 kHz
// - commands always actively driven, never floating
// - controller drops all commands within 12 us
// - controller stops motor on overtemperature
// - wait two seconds before resuming after overcurrent
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "tpgip_defines.vh"
module tpgip_ctrl #(
	parameter CW         = 16,
	parameter RESUME_CYC = `TPGIP_RESUME_CYC
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst_b,
	// software port
	input  wire [3:0]  addr,
	input  wire [15:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [15:0] rdata,
	// device pins
	input  wire        fault_out_n,
	input  wire        over_temperature,
	output reg  [2:0]  high_side_command,
	output reg  [2:0]  low_side_command,
	// status
	output reg         fault_seen
);
	reg [CW-1:0]   period;
	reg [CW-1:0]   dead;
	reg [3*CW-1:0] duty;
	reg            run;
	reg            latch;
	reg            fault_q;
	reg [CW-1:0]   count;
	reg [CW-1:0]   per_eff;
	reg [CW-1:0]   dead_eff;
	wire [2:0]     ph_high;
	wire [2:0]     ph_low;
	wire           waiting;
	wire           fault_fall;
	wire           enable;
	reg            next_latch;
	localparam integer PER_MIN  = `TPGIP_PER_MIN_CYC;
	localparam integer PER_MAX  = `TPGIP_PER_MAX_CYC;
	localparam integer DEAD_MIN = `TPGIP_DEAD_CYC;

	// fault line is active low; a falling edge is a new fault
	assign fault_fall = fault_q & ~fault_out_n;
	// any fault, latched stop, wait or heat drops every command at once
	assign enable = run & fault_out_n & ~latch & ~waiting & ~over_temperature;

	// clamp period to legal carrier and dead time to the minimum
	always @* begin
		per_eff = period;
		if (period < `TPGIP_PER_MIN_CYC)
			per_eff = PER_MIN[CW-1:0];
		else if (period > `TPGIP_PER_MAX_CYC)
			per_eff = PER_MAX[CW-1:0];
		dead_eff = dead;
		if (dead < `TPGIP_DEAD_CYC)
			dead_eff = DEAD_MIN[CW-1:0];
	end

	// set wins over a software clear in the same cycle
	always @* begin
		next_latch = latch;
		if (wr && addr == `TPGIP_A_CTRL && wdata[`TPGIP_C_CLRLATCH])
			next_latch = 1'b0;
		if (fault_fall || over_temperature)
			next_latch = 1'b1;
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			period     <= `TPGIP_PER_RST;
			dead       <= `TPGIP_ZERO16;
			duty       <= {3*CW{1'b0}};
			run        <= 1'b0;
			latch      <= 1'b0;
			fault_q    <= 1'b1;
			count      <= {CW{1'b0}};
			rdata      <= `TPGIP_ZERO16;
			fault_seen <= 1'b0;
		end else begin
			fault_q    <= fault_out_n;
			latch      <= next_latch;
			fault_seen <= ~fault_out_n;
			if (count >= per_eff - 1'b1)
				count <= {CW{1'b0}};
			else
				count <= count + 1'b1;
			if (wr) begin
				case (addr)
				`TPGIP_A_CTRL:   run    <= wdata[`TPGIP_C_RUN];
				`TPGIP_A_PERIOD: period <= wdata[CW-1:0];
				`TPGIP_A_DEAD:   dead   <= wdata[CW-1:0];
				default: begin
					if (addr >= `TPGIP_A_DUTY0 && addr < `TPGIP_A_DUTY0 + 4'h3)
						duty[(addr - `TPGIP_A_DUTY0)*CW +: CW] <= wdata[CW-1:0];
				end
				endcase
			end
			if (rd) begin
				case (addr)
				`TPGIP_A_CTRL:   rdata <= {15'h0000, run};
				`TPGIP_A_PERIOD: rdata <= period;
				`TPGIP_A_DEAD:   rdata <= dead;
				`TPGIP_A_DUTY0:  rdata <= duty[CW-1:0];
				`TPGIP_A_DUTY0 + 4'h1: rdata <= duty[2*CW-1:CW];
				`TPGIP_A_DUTY0 + 4'h2: rdata <= duty[3*CW-1:2*CW];
				`TPGIP_A_STATUS: rdata <= {11'h000, over_temperature, waiting,
					latch, ~fault_out_n, enable};
				default:         rdata <= `TPGIP_ZERO16;
				endcase
			end else begin
				rdata <= `TPGIP_ZERO16;
			end
		end
	end

	// long wait after each fault edge, overcurrent or undervoltage alike
	tpgip_resume #(
		.RESUME_CYC (RESUME_CYC)
	) u_resume (
		.clk     (clk),
		.rst_b   (rst_b),
		.start   (fault_fall),
		.waiting (waiting)
	);

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_phase
			tpgip_phase #(
				.CW (CW)
			) u_phase (
				.clk               (clk),
				.rst_b             (rst_b),
				.enable            (enable),
				.count             (count),
				.duty              (duty[g*CW +: CW]),
				.dead              (dead_eff),
				.high_side_command (ph_high[g]),
				.low_side_command  (ph_low[g])
			);
		end
	endgenerate

	// outputs registered once more; fault mask here drops commands one cycle later, far inside 12 us
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			high_side_command <= 3'h0;
			low_side_command  <= 3'h0;
		end else begin
			high_side_command <= ph_high & {3{fault_out_n}};
			low_side_command  <= ph_low  & {3{fault_out_n}};
		end
	end
endmodule

// *** sim/tpgip_props.sv ***
// checker on the gate command controller ports
// assumes bind to tpgip_ctrl with a short resume wait
`timescale 1ns/1ps
module tpgip_props #(
	parameter CW         = 16,
	parameter RESUME_CYC = 100
) (
	// clock and reset
	input wire        clk,
	input wire        rst_b,
	// port and pins
	input wire        rd,
	input wire [15:0] rdata,
	input wire        fault_out_n,
	input wire        over_temperature,
	input wire [2:0]  high_side_command,
	input wire [2:0]  low_side_command,
	input wire        fault_seen
);
	// sized for the short wait used in sim
	localparam [7:0] RC = RESUME_CYC;
	wire [2:0]  h = high_side_command;
	wire [2:0]  l = low_side_command;
	reg  [12:0] g;
	reg  [7:0]  d;
	reg  [7:0]  w;
	// a dark spell of 255 cycles is a stop; restart gaps are not carrier periods
	reg  [1:0]  k;
	// phase 0 only: all phases share one carrier
	always @(posedge clk or negedge rst_b)
		if (!rst_b) begin
			g <= 13'h1FFF;
			d <= 8'hFF;
			w <= 8'h00;
			k <= 2'h0;
		end else begin
			k <= (&d) ? 2'h0 : k + {1'b0, $rose(h[0]) & ~k[1]};
			g <= $rose(h[0]) ? 13'h0000 : g + {12'h000, ~&g};
			d <= h[0] | l[0] ? 8'h00 : d + {7'h00, ~&d};
			w <= $fell(fault_out_n) ? RC : w - {7'h00, |w};
		end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_dark; (h | l) == 3'h0; endsequence
	property p_excl; (h & l) == 3'h0; endproperty
	a_excl: assert property (p_excl) else $error("pair high");
	property p_fault; !fault_out_n |=> s_dark ##0 fault_seen; endproperty
	a_fault: assert property (p_fault) else $error("fault ignored");
	property p_seen; fault_out_n |=> !fault_seen; endproperty
	a_seen: assert property (p_seen) else $error("stale fault");
	property p_hot; over_temperature |-> ##[1:2] s_dark; endproperty
	a_hot: assert property (p_hot) else $error("hot ignored");
	property p_dead; $rose(h[0]) || $rose(l[0]) |-> d >= 8'h28; endproperty
	a_dead: assert property (p_dead) else $error("dead short");
	property p_gap; $rose(h[0]) && k[1] |-> g >= 13'h03E7; endproperty
	a_gap: assert property (p_gap) else $error("period short");
	property p_wait; w != 8'h00 |-> s_dark; endproperty
	a_wait: assert property (p_wait) else $error("early resume");
	property p_rdz; !rd |=> rdata == 16'h0000; endproperty
	a_rdz: assert property (p_rdz) else $error("read data stuck");
endmodule
bind tpgip_ctrl tpgip_props #(.CW(CW), .RESUME_CYC(RESUME_CYC)) u_props (
	.clk(clk), .rst_b(rst_b), .rd(rd), .rdata(rdata), .fault_out_n(fault_out_n),
	.over_temperature(over_temperature), .high_side_command(high_side_command),
	.low_side_command(low_side_command), .fault_seen(fault_seen)
);

// *** sim/tpgip_dev_model.sv ***
// behavioural model of the driven power stage logic
// assumes stimuli change after clk edges; logic-supply filter not modelled
`timescale 1ns/1ps
module tpgip_dev_model (
	// filter clock
	input  wire       clk,
	// commands
	input  wire [2:0] high_side_command,
	input  wire [2:0] low_side_command,
	// protection stimuli
	input  wire       overcurrent_sense,
	input  wire       logic_supply_undervoltage_lock,
	input  wire [2:0] bootstrap_undervoltage_lock,
	// outputs
	output wire       fault_out_n,
	output reg  [2:0] high_gate_drive = 3'h0,
	output wire [2:0] low_gate_drive
);
	reg  [2:0] hq = 3'h0;
	reg  [2:0] ocf = 3'h0;
	reg  [7:0] hold = 8'h00;
	reg  [2:0] bsl = 3'h0;
	reg  [17:0] bcnt = 18'h0_0000;
	integer    k;
	wire       fault_pull_transistor = logic_supply_undervoltage_lock | (|hold);
	// pull-up gives high whenever the transistor is off
	assign fault_out_n = fault_pull_transistor ? 1'b0 : 1'b1;
	assign low_gate_drive = fault_pull_transistor ? 3'h0 : low_side_command;
	always @(posedge clk) begin
		ocf <= overcurrent_sense ? ocf + {2'h0, ocf != 3'h6} : 3'h0;
		// six samples stand for the sense filter, 240 cycles for the hold
		if (overcurrent_sense && ocf == 3'h5)
			hold <= 8'hF0;
		else if (|hold)
			hold <= hold - 8'h01;
		// a lock change must stand about 1.8 us (36 cycles) before it counts
		for (k = 0; k < 3; k = k + 1)
			if (bootstrap_undervoltage_lock[k] == bsl[k])
				bcnt[k*6 +: 6] <= 6'h00;
			else if (bcnt[k*6 +: 6] == 6'h23) begin
				bsl[k]         <= bootstrap_undervoltage_lock[k];
				bcnt[k*6 +: 6] <= 6'h00;
			end else
				bcnt[k*6 +: 6] <= bcnt[k*6 +: 6] + 6'h01;
		hq <= high_side_command;
		high_gate_drive <= ~bsl & high_side_command
			& (high_gate_drive | ~hq);
	end
endmodule

// *** sim/tpgip_ctrl_test.sv ***
// self-checking bench for the gate command controller
// assumes the device model on the pins and a 20 MHz clock
`timescale 1ns/1ps
`include "tpgip_defines.vh"
module tpgip_ctrl_test;
	reg         clk, rst_b, wr, rd, ot, oc, uv;
	reg  [3:0]  addr;
	reg  [15:0] wdata, rv;
	wire [15:0] rdata;
	wire [2:0]  h, l;
	wire        fo_n, fs;
	integer     err_total, n_tests;
	tpgip_ctrl #(.CW(16), .RESUME_CYC(100)) uut (
		.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .fault_out_n(fo_n), .over_temperature(ot),
		.high_side_command(h), .low_side_command(l), .fault_seen(fs));
	tpgip_dev_model dev (
		.clk(clk), .high_side_command(h), .low_side_command(l),
		.overcurrent_sense(oc), .logic_supply_undervoltage_lock(uv),
		.bootstrap_undervoltage_lock(3'h0), .fault_out_n(fo_n),
		.high_gate_drive(), .low_gate_drive());
	task chk(input [15:0] got, input [15:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr_reg(input [3:0] a, input [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask
	task rd_reg(input [3:0] a);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 rv = rdata;
	endtask
	// two carrier periods hold exactly two rises on each of six lines
	task cnt_rises;
		integer    i;
		reg [15:0] n;
		reg [5:0]  q;
		n = 16'h0000;
		q = {h, l};
		for (i = 0; i < 2000; i = i + 1) begin
			@(posedge clk);
			#1 n = n + 16'($countones({h, l} & ~q));
			q = {h, l};
		end
		chk(n, 16'h000C);
	endtask
	task t_regs;
		rd_reg(`TPGIP_A_STATUS);
		chk(rv, 16'h0000);
		rd_reg(`TPGIP_A_PERIOD);
		chk(rv, `TPGIP_PER_RST);
		wr_reg(4'hF, 16'hFFFF);
		rd_reg(4'hF);
		chk(rv, 16'h0000);
		$display("test regs done");
	endtask
	task t_run;
		wr_reg(`TPGIP_A_DEAD, 16'h0028);
		wr_reg(`TPGIP_A_DUTY0, 16'h01F4);
		wr_reg(4'h3, 16'h00C8);
		wr_reg(4'h4, 16'h0320);
		wr_reg(`TPGIP_A_CTRL, 16'h0001);
		rd_reg(`TPGIP_A_STATUS);
		chk(rv, 16'h0001);
		repeat (1000) @(posedge clk);
		cnt_rises;
		$display("test run done");
	endtask
	task t_fault(input sel);
		integer i;
		@(posedge clk);
		{uv, oc} <= sel ? 2'h2 : 2'h1;
		for (i = 0; i < 20 && fs !== 1'b1; i = i + 1)
			@(posedge clk);
		#1 chk({10'h000, h, l}, 16'h0000);
		rd_reg(`TPGIP_A_STATUS);
		chk(rv & 16'h0006, 16'h0006);
		@(posedge clk);
		{uv, oc} <= 2'h0;
		// latch cleared early: the resume wait, and for overcurrent also the device hold, keeps the pins dark
		wr_reg(`TPGIP_A_CTRL, 16'h0005);
		#1 chk({10'h000, h, l}, 16'h0000);
		rd_reg(`TPGIP_A_STATUS);
		chk(rv & 16'h000C, 16'h0008);
		wr_reg(`TPGIP_A_CTRL, 16'h0000);
		// past the device hold and the resume wait
		repeat (300) @(posedge clk);
		rd_reg(`TPGIP_A_STATUS);
		chk(rv & 16'h000E, 16'h0000);
		chk({10'h000, h, l}, 16'h0000);
		wr_reg(`TPGIP_A_CTRL, 16'h0005);
		repeat (1000) @(posedge clk);
		cnt_rises;
		$display("test fault done");
	endtask
	task t_hot;
		@(posedge clk);
		ot <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk({10'h000, h, l}, 16'h0000);
		rd_reg(`TPGIP_A_STATUS);
		chk(rv & 16'h0010, 16'h0010);
		@(posedge clk);
		ot <= 1'b0;
		// stop stays latched after the heat is gone
		repeat (300) @(posedge clk);
		#1 chk({10'h000, h, l}, 16'h0000);
		wr_reg(`TPGIP_A_CTRL, 16'h0005);
		repeat (1000) @(posedge clk);
		cnt_rises;
		$display("test hot done");
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#2000000;
		err_total = err_total + 1;
		test_done;
	end
	initial begin
		{rst_b, wr, rd, ot, oc, uv, addr, wdata} = 0;
		{err_total, n_tests} = 0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		t_regs;
		t_run;
		t_fault(1'b0);
		t_fault(1'b1);
		t_hot;
		test_done;
	end
endmodule
